/* core/p34_pinmux.sv */
/*
  Pin function select for port 3 (7 pins) and port 4 (8 input pins).
  Assumes serial channel mode bits arrive as levels on pclk and pins
  are already synchronous to pclk.
*/
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module p34_pinmux (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic hw_standby,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [6:0] p3_pin_i,
  output logic [6:0] p3_pin_o,
  output logic [6:0] p3_pin_oe,
  input wire logic [7:0] p4_pin_i,
  input wire logic [1:0] clock_enable_high,
  input wire logic [1:0] clock_enable_low,
  input wire logic [1:0] clocked_mode,
  input wire logic [1:0] receive_enable_bit,
  input wire logic [1:0] transmit_enable_bit,
  input wire logic [1:0] serial_clock_out,
  input wire logic [1:0] transmit_line,
  output logic [1:0] serial_clock_in,
  output logic [1:0] receive_line,
  output logic [7:0] expansion_interrupt_in_n,
  output logic [1:0] external_interrupt_in_n
);
  typedef struct packed {
    logic [6:0] pin_o;
    logic [6:0] pin_oe;
    logic [7:0] xint_n;
    logic [1:0] irq_n;
    logic [1:0] sck_in;
    logic [1:0] rxd;
  } p34_mux_state_type;

  p34_mux_state_type st_ff;
  p34_mux_state_type nxt_st;
  p34_reg_if rif ();
  logic [6:0] fn_in;
  logic [6:0] fn_out;
  logic [6:0] fn_val;
  logic [6:0] cell_o;
  logic [6:0] cell_oe;
  logic [1:0] ck_in;
  logic [1:0] ck_out;

  ////////////////////////////////////////////////////////////////////
  p34_apb_regs u_regs (
    .pclk(pclk),
    .presetn(presetn),
    .hw_standby(hw_standby),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .rif(rif.regs)
  );

  ////////////////////////////////////////////////////////////////////
  always_comb begin
    // Clock input outranks clock output on both channels
    ck_in = clock_enable_high; // see [R08] see [R09]
    ck_out = ~clock_enable_high & (clocked_mode | clock_enable_low); // see [R08] see [R09]
    fn_in = 7'h00;
    fn_out = 7'h00;
    fn_val = 7'h00;
    fn_in[p34_pkg::PIN_XI7] = rif.ipinsel[p34_pkg::SEL_XINT7]; // see [R06]
    fn_in[p34_pkg::PIN_CK1] = ck_in[1];
    fn_out[p34_pkg::PIN_CK1] = ck_out[1];
    fn_val[p34_pkg::PIN_CK1] = serial_clock_out[1];
    fn_in[p34_pkg::PIN_RX1] = receive_enable_bit[1]; // see [R12]
    fn_out[p34_pkg::PIN_TX1] = transmit_enable_bit[1]; // see [R13]
    fn_val[p34_pkg::PIN_TX1] = transmit_line[1];
    fn_in[p34_pkg::PIN_CK0] = ck_in[0];
    fn_out[p34_pkg::PIN_CK0] = ck_out[0];
    fn_val[p34_pkg::PIN_CK0] = serial_clock_out[0];
    fn_in[p34_pkg::PIN_RX0] = receive_enable_bit[0]; // see [R14]
    fn_out[p34_pkg::PIN_TX0] = transmit_enable_bit[0]; // see [R15]
    fn_val[p34_pkg::PIN_TX0] = transmit_line[0];
  end

  for (genvar i = 0; i < p34_pkg::P3_W; i++) begin : g_pin
    p34_pin_cell u_cell (
      .fn_in(fn_in[i]),
      .fn_out(fn_out[i]),
      .fn_val(fn_val[i]),
      .ddr(rif.ddr[i]),
      .dr(rif.dr[i]),
      .odr(rif.odr[i]),
      .pin_o(cell_o[i]),
      .pin_oe(cell_oe[i])
    );
    // Output pins read back the data bit, inputs read the pad
    assign rif.p3_read[i] = rif.ddr[i] ? rif.dr[i] : p3_pin_i[i];
  end
  assign rif.p4_read = p4_pin_i; // see [R16]

  ////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_st.pin_o = cell_o;
    nxt_st.pin_oe = cell_oe;
    // Unrouted interrupt lines idle high so they never fire
    nxt_st.xint_n[7] = rif.ipinsel[p34_pkg::SEL_XINT7] ? p3_pin_i[p34_pkg::PIN_XI7] : 1'b1; // see [R04]
    for (int k = 0; k < 7; k++) begin
      nxt_st.xint_n[k] = rif.ipinsel[k] ? p4_pin_i[p34_pkg::P4_MAP[k]] : 1'b1; // see [R05]
    end
    // Plain inputs also watch irq lines; sharing is software's problem.
    // Judged by the direction bit, not the enable: an open-drain output
    // releasing its pad for a high is still an output.
    nxt_st.irq_n[1] = (!rif.ddr[p34_pkg::PIN_CK1] && !fn_in[p34_pkg::PIN_CK1]
                       && !fn_out[p34_pkg::PIN_CK1]) ? p3_pin_i[p34_pkg::PIN_CK1] : 1'b1; // see [R10]
    nxt_st.irq_n[0] = (!rif.ddr[p34_pkg::PIN_CK0] && !fn_in[p34_pkg::PIN_CK0]
                       && !fn_out[p34_pkg::PIN_CK0]) ? p3_pin_i[p34_pkg::PIN_CK0] : 1'b1; // see [R10]
    nxt_st.sck_in[1] = ck_in[1] ? p3_pin_i[p34_pkg::PIN_CK1] : 1'b1; // see [R08]
    nxt_st.sck_in[0] = ck_in[0] ? p3_pin_i[p34_pkg::PIN_CK0] : 1'b1; // see [R09]
    // Receivers see an idle mark line while not enabled
    nxt_st.rxd[1] = receive_enable_bit[1] ? p3_pin_i[p34_pkg::PIN_RX1] : 1'b1; // see [R12]
    nxt_st.rxd[0] = receive_enable_bit[0] ? p3_pin_i[p34_pkg::PIN_RX0] : 1'b1; // see [R14]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '{pin_o: 7'h00, pin_oe: 7'h00, xint_n: 8'hFF, irq_n: 2'h3, sck_in: 2'h3, rxd: 2'h3};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign p3_pin_o = st_ff.pin_o;
  assign p3_pin_oe = st_ff.pin_oe;
  assign expansion_interrupt_in_n = st_ff.xint_n;
  assign external_interrupt_in_n = st_ff.irq_n;
  assign serial_clock_in = st_ff.sck_in;
  assign receive_line = st_ff.rxd;

  ////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  xint7_route_a: assert property (rif.ipinsel[7] |=> expansion_interrupt_in_n[7] == $past(p3_pin_i[6]) // see [R04]
    && !p3_pin_oe[6]) // see [R06]
    else $error("pin 36 not routed to xint7");
  xint_idle_a: assert property (!rif.ipinsel[0] |=> expansion_interrupt_in_n[0]) // see [R05]
    else $error("unselected xint0 not idle");
  xint6_route_a: assert property (rif.ipinsel[6] |=> expansion_interrupt_in_n[6] == $past(p4_pin_i[7])) // see [R05]
    else $error("port 4 pin 7 not routed to xint6");
  open_drain_low_a: assert property (rif.odr[3] |=> !p3_pin_o[3]) // see [R07]
    else $error("open-drain pin driven high");
  tx_drive_a: assert property (transmit_enable_bit[0] && !rif.odr[0]
    |=> p3_pin_oe[0] && p3_pin_o[0] == $past(transmit_line[0])) // see [R15]
    else $error("transmit line not on pin 30");
  rx_route_a: assert property (receive_enable_bit[1] |=> receive_line[1] == $past(p3_pin_i[4])) // see [R12]
    else $error("pin 34 not routed to receiver");
  clk_in_wins_a: assert property (clock_enable_high[1] |=> !p3_pin_oe[5]
    && serial_clock_in[1] == $past(p3_pin_i[5])) // see [R08]
    else $error("clock input pin 35 driven");
  clk0_out_a: assert property (!clock_enable_high[0] && clock_enable_low[0] && !rif.odr[2]
    |=> p3_pin_oe[2] && p3_pin_o[2] == $past(serial_clock_out[0])) // see [R09]
    else $error("pin 32 clock output missing");
  external_interrupt_in_5_gpin_a: assert property (!clock_enable_high[1] && !clocked_mode[1] && !clock_enable_low[1]
    && !rif.ddr[5] |=> external_interrupt_in_n[1] == $past(p3_pin_i[5])) // see [R10]
    else $error("pin 35 level not on external_interrupt_in_5");
  gpio_out_a: assert property (rif.ddr[4] && !receive_enable_bit[1] && !rif.odr[4]
    |=> p3_pin_oe[4] && p3_pin_o[4] == $past(rif.dr[4])) // see [R17] see [R18]
    else $error("general output not driven from data bit");

  cover_xint7_c: cover property (rif.ipinsel[7] ##1 !expansion_interrupt_in_n[7]);
  cover_clk_out_c: cover property (p3_pin_oe[5] && clocked_mode[1]);
  cover_tx1_c: cover property (transmit_enable_bit[1] && p3_pin_oe[3]);
endmodule : p34_pinmux
`default_nettype wire

/* core/p34_pkg.sv */
/*
  Constants for the port 3 / port 4 pin function select block.
  Assumes a 32-bit APB slave interface and one 50 MHz clock.
*/
// Overview of operation
// [R01] Eight-bit RW interrupt pin select register
// [R02] Select register cleared by reset, hardware standby
// [R03] Select register kept through manual reset
// [R04] Select bit 7 routes pin 36 to xint7
// [R05] Bits 6..0 route port 4 pins to xint6..0
// [R06] Pin 36: xint7 input, else direction controlled
// [R07] Open-drain bit makes outputs drive low only
// [R08] Pin 35: clock in, clock out, or GPIO
// [R09] Pin 32: same clock choice using channel 0
// [R10] General-input pins 35, 32 feed external_interrupt_in_5, external_interrupt_in_4
// [R11] Software avoids sharing an interrupt pin
// [R12] Pin 34 is channel 1 receive when enabled
// [R13] Pin 33 is channel 1 transmit when enabled
// [R14] Pin 31 is channel 0 receive when enabled
// [R15] Pin 30 is channel 0 transmit when enabled
// [R16] Port 4 is eight input-only pins
// [R17] Direction bit 1 output, 0 input
// [R18] Plain output pins drive the data bit
package p34_pkg;

  localparam int P3_W = 7;
  localparam int P4_W = 8;
  localparam int XINT_W = 8;

  // Register byte offsets
  localparam logic [11:0] OFS_IPINSEL = 12'h000;
  localparam logic [11:0] OFS_DDR = 12'h004;
  localparam logic [11:0] OFS_DR = 12'h008;
  localparam logic [11:0] OFS_ODR = 12'h00C;
  localparam logic [11:0] OFS_PORT3 = 12'h010;
  localparam logic [11:0] OFS_PORT4 = 12'h014;

  // Reset values
  localparam logic [7:0] IPINSEL_RST = 8'h00;
  localparam logic [6:0] P3CFG_RST = 7'h00;

  // Select register field positions
  localparam int SEL_XINT7 = 7;

  // Port 3 pin numbers
  localparam int PIN_TX0 = 0;
  localparam int PIN_RX0 = 1;
  localparam int PIN_CK0 = 2;
  localparam int PIN_TX1 = 3;
  localparam int PIN_RX1 = 4;
  localparam int PIN_CK1 = 5;
  localparam int PIN_XI7 = 6;

  // Port 4 pin feeding each of xint6..0
  localparam logic [2:0] P4_MAP [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h6, 3'h7};

endpackage : p34_pkg

/* core/p34_reg_if.sv */
/*
  Carries the pin configuration from the register file to the pin logic.
  Assumes both ends run on the same pclk.
*/
`timescale 1ns/1ps
`default_nettype none
interface p34_reg_if;
  logic [7:0] ipinsel;
  logic [6:0] ddr;
  logic [6:0] dr;
  logic [6:0] odr;
  logic [6:0] p3_read;
  logic [7:0] p4_read;
  modport regs (output ipinsel, ddr, dr, odr, input p3_read, p4_read);
  modport core (input ipinsel, ddr, dr, odr, output p3_read, p4_read);
endinterface : p34_reg_if
`default_nettype wire

/* core/p34_pin_cell.sv */
/*
  One port 3 pad: chooses the driven value and enable for a pin.
  Assumes the caller registers the result.
*/
`timescale 1ns/1ps
`default_nettype none
module p34_pin_cell (
  input wire logic fn_in,
  input wire logic fn_out,
  input wire logic fn_val,
  input wire logic ddr,
  input wire logic dr,
  input wire logic odr,
  output logic pin_o,
  output logic pin_oe
);
  logic drive;
  logic val;

  always_comb begin
    // A peripheral input wins over the direction bit
    drive = !fn_in && (fn_out || ddr); // see [R17]
    val = fn_out ? fn_val : dr; // see [R18]
    // Open drain only ever pulls low; high is left to the pull-up
    pin_oe = drive && !(odr && val); // see [R07]
    pin_o = odr ? 1'b0 : val; // see [R07]
  end
endmodule : p34_pin_cell
`default_nettype wire

/* core/p34_apb_regs.sv */
/*
  APB register file for the pin select and port 3 configuration.
  Assumes a standard APB master on pclk; one wait state per access.
*/
`timescale 1ns/1ps
`default_nettype none
module p34_apb_regs (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic hw_standby,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  p34_reg_if.regs rif
);
  typedef struct packed {
    logic [7:0] sel;
    logic [6:0] ddr;
    logic [6:0] dr;
    logic [6:0] odr;
    logic [31:0] rdata;
    logic rdy;
    logic err;
  } p34_apb_state_type;

  p34_apb_state_type st_ff;
  p34_apb_state_type nxt_st;
  logic hit;
  logic [31:0] rd;
  logic wr_now;

  ////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_st = st_ff;
    hit = 1'b1;
    rd = 32'h0000_0000;
    // Write-only direction register reads back zero
    if (paddr == p34_pkg::OFS_IPINSEL) begin
      rd = {24'h00_0000, st_ff.sel}; // see [R01]
    end else if (paddr == p34_pkg::OFS_DDR) begin
      rd = 32'h0000_0000;
    end else if (paddr == p34_pkg::OFS_DR) begin
      rd = {25'h000_0000, st_ff.dr};
    end else if (paddr == p34_pkg::OFS_ODR) begin
      rd = {25'h000_0000, st_ff.odr};
    end else if (paddr == p34_pkg::OFS_PORT3) begin
      rd = {25'h000_0000, rif.p3_read};
    end else if (paddr == p34_pkg::OFS_PORT4) begin
      rd = {24'h00_0000, rif.p4_read}; // see [R16]
    end else begin
      hit = 1'b0;
    end
    wr_now = psel && penable && st_ff.rdy && pwrite && hit;
    nxt_st.rdy = psel && penable && !st_ff.rdy;
    nxt_st.err = psel && penable && !st_ff.rdy && !hit;
    if (psel && penable && !st_ff.rdy) begin
      nxt_st.rdata = (pwrite || !hit) ? 32'h0000_0000 : rd;
    end
    if (wr_now) begin
      if (paddr == p34_pkg::OFS_IPINSEL) begin
        nxt_st.sel = pwdata[7:0]; // see [R01]
      end else if (paddr == p34_pkg::OFS_DDR) begin
        nxt_st.ddr = pwdata[6:0];
      end else if (paddr == p34_pkg::OFS_DR) begin
        nxt_st.dr = pwdata[6:0];
      end else if (paddr == p34_pkg::OFS_ODR) begin
        nxt_st.odr = pwdata[6:0];
      end
    end
    // Hardware standby clears config; manual reset never reaches here
    if (hw_standby) begin
      nxt_st.sel = p34_pkg::IPINSEL_RST; // see [R02] see [R03]
      nxt_st.ddr = p34_pkg::P3CFG_RST;
      nxt_st.dr = p34_pkg::P3CFG_RST;
      nxt_st.odr = p34_pkg::P3CFG_RST;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '{sel: p34_pkg::IPINSEL_RST, ddr: p34_pkg::P3CFG_RST, dr: p34_pkg::P3CFG_RST,
                 odr: p34_pkg::P3CFG_RST, rdata: 32'h0000_0000, rdy: 1'b0, err: 1'b0}; // see [R02]
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign prdata = st_ff.rdata;
  assign pready = st_ff.rdy;
  assign pslverr = st_ff.err;
  assign rif.ipinsel = st_ff.sel;
  assign rif.ddr = st_ff.ddr;
  assign rif.dr = st_ff.dr;
  assign rif.odr = st_ff.odr;

  ////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  standby_clears_sel_a: assert property (hw_standby |=> st_ff.sel == 8'h00) // see [R02]
    else $error("select register not cleared in standby");
  sel_write_lands_a: assert property (wr_now && paddr == p34_pkg::OFS_IPINSEL && !hw_standby
    |=> st_ff.sel == $past(pwdata[7:0])) // see [R01]
    else $error("select register write lost");
  sel_holds_a: assert property (!wr_now && !hw_standby |=> $stable(st_ff.sel)) // see [R03]
    else $error("select register changed without write");
  cover_sel_write_c: cover property (wr_now && paddr == p34_pkg::OFS_IPINSEL);
  cover_unmapped_c: cover property (st_ff.err);
endmodule : p34_apb_regs
`default_nettype wire

/* dv/p34_pad_model.sv */
/*
  Pad-side model of the parts wired to port 3 and port 4 pins.
  Assumes the bench sets which port 3 pads an outside part drives.
*/
`timescale 1ns/1ps
`default_nettype none
module p34_pad_model (
  input wire logic [6:0] p3_pin_o,
  input wire logic [6:0] p3_pin_oe,
  input wire logic [6:0] ext_en,
  input wire logic [6:0] ext_val,
  input wire logic [7:0] p4_val,
  output logic [6:0] p3_pin_i,
  output logic [7:0] p4_pin_i
);
  ////////////////////////////////////////////////////////////
  // Released pads float up, so open-drain highs read as 1
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      if (p3_pin_oe[i])
        p3_pin_i[i] = p3_pin_o[i];
      else if (ext_en[i])
        p3_pin_i[i] = ext_val[i];
      else
        p3_pin_i[i] = 1'b1;
    end
  end
  assign p4_pin_i = p4_val;
endmodule : p34_pad_model
`default_nettype wire

/* dv/test_port3_port4_pin_function_select.sv */
/*
  Self-checking bench for the port 3 / port 4 pin function select.
  Assumes the p34_pinmux top, its package and the pad model.
*/
`timescale 1ns/1ps
`default_nettype none
module test_port3_port4_pin_function_select;
  logic pclk, presetn, hw_standby, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [6:0] p3_pin_i, p3_pin_o, p3_pin_oe, ext_en, ext_val;
  logic [7:0] p4_pin_i, p4_val, expansion_interrupt_in_n, sel;
  logic [1:0] clock_enable_high, clock_enable_low, clocked_mode, receive_enable_bit;
  logic [1:0] transmit_enable_bit, serial_clock_out, transmit_line, serial_clock_in;
  logic [1:0] receive_line, external_interrupt_in_n;
  logic err, inp;
  int num_errors = 0;
  int tests_run = 0;

  p34_pinmux uut (.pclk, .presetn, .hw_standby, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .p3_pin_i, .p3_pin_o, .p3_pin_oe, .p4_pin_i,
    .clock_enable_high, .clock_enable_low, .clocked_mode, .receive_enable_bit,
    .transmit_enable_bit, .serial_clock_out, .transmit_line, .serial_clock_in,
    .receive_line, .expansion_interrupt_in_n, .external_interrupt_in_n);
  p34_pad_model pads (.p3_pin_o, .p3_pin_oe, .ext_en, .ext_val, .p4_val, .p3_pin_i, .p4_pin_i);

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  ////////////////////////////////////////////////////////////
  task end_sim;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_sim

  task check_reg(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check_reg

  task check_pin(input logic [7:0] got, input logic [7:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t pins %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check_pin

  // Holds the request until pready is seen high at an edge
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50)
      check_reg(32'h0, 32'h1, "apb answer missing");
  endtask : apb

  task rchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check_reg(rd, exp, "read");
  endtask : rchk

  // Outputs are registered; let config and pads land
  task settle;
    repeat (3) @(posedge pclk);
    #1;
  endtask : settle

  function automatic logic [7:0] exp_x(input logic [7:0] s, input logic p36, input logic [7:0] p4);
    return {p36, p4[7], p4[6], p4[4], p4[3], p4[2], p4[1], p4[0]} | ~s;
  endfunction : exp_x

  ////////////////////////////////////////////////////////////
  initial begin
    {presetn, hw_standby, psel, penable, pwrite, paddr, pwdata} = '0;
    {clock_enable_high, clock_enable_low, clocked_mode, receive_enable_bit} = '0;
    {transmit_enable_bit, serial_clock_out, transmit_line} = '0;
    {ext_en, ext_val, p4_val} = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rchk(p34_pkg::OFS_IPINSEL, 32'h0);
    rchk(p34_pkg::OFS_DR, 32'h0);
    rchk(p34_pkg::OFS_ODR, 32'h0);
    apb(1'b0, 12'h018, 32'h0);
    check_reg({31'h0, err}, 32'h1, "unmapped");
    foreach (sel[i]) begin
      apb(1'b1, p34_pkg::OFS_IPINSEL, {24'h0, 8'h1 << i});
      rchk(p34_pkg::OFS_IPINSEL, {24'h0, 8'h1 << i});
    end
    $display("test registers done");
    // Pin 36 driven low from outside only while not an output
    @(posedge pclk);
    ext_en <= 7'h40;
    for (int k = 0; k < 4; k++) begin
      sel = (k == 0) ? 8'hFF : (k == 1) ? 8'h00 : (k == 2) ? 8'h81 : 8'h7E;
      apb(1'b1, p34_pkg::OFS_IPINSEL, {24'h0, sel});
      p4_val <= k[0] ? 8'h69 : 8'h96;
      settle();
      check_pin(expansion_interrupt_in_n, exp_x(sel, 1'b0, p4_val), "xint");
      rchk(p34_pkg::OFS_PORT4, {24'h0, p4_val});
    end
    $display("test expansion interrupts done");
    apb(1'b1, p34_pkg::OFS_IPINSEL, 32'h0);
    apb(1'b1, p34_pkg::OFS_DDR, 32'h7F);
    apb(1'b1, p34_pkg::OFS_DR, 32'h55);
    settle();
    check_pin({1'b0, p3_pin_oe}, 8'h7F, "oe out");
    check_pin({1'b0, p3_pin_o}, 8'h55, "data");
    rchk(p34_pkg::OFS_PORT3, 32'h55);
    apb(1'b1, p34_pkg::OFS_IPINSEL, 32'h80);
    settle();
    check_pin({1'b0, p3_pin_oe}, 8'h3F, "xint7 claims pin");
    apb(1'b1, p34_pkg::OFS_IPINSEL, 32'h0);
    apb(1'b1, p34_pkg::OFS_ODR, 32'h7F);
    transmit_enable_bit <= 2'b01;
    transmit_line <= 2'b00;
    settle();
    check_pin({1'b0, p3_pin_oe}, 8'h2B, "open drain oe");
    check_pin({1'b0, p3_pin_o}, 8'h00, "open drain o");
    $display("test outputs done");
    apb(1'b1, p34_pkg::OFS_ODR, 32'h0);
    apb(1'b1, p34_pkg::OFS_DDR, 32'h0);
    transmit_enable_bit <= 2'b11;
    transmit_line <= 2'b10;
    ext_en <= 7'h36;
    ext_val <= 7'h14;
    settle();
    check_pin({1'b0, p3_pin_oe}, 8'h09, "tx oe");
    check_pin({6'h0, p3_pin_o[3], p3_pin_o[0]}, 8'h02, "tx o");
    check_pin({6'h0, receive_line}, 8'h03, "rx off");
    @(posedge pclk);
    transmit_enable_bit <= 2'b00;
    receive_enable_bit <= 2'b11;
    settle();
    check_pin({6'h0, receive_line}, 8'h02, "rx on");
    receive_enable_bit <= 2'b00;
    serial_clock_out <= 2'b01;
    for (int m = 0; m < 4; m++) begin
      inp = (m == 0 || m == 3);
      clock_enable_high <= {2{inp}};
      clocked_mode <= {2{m == 1 || m == 3}};
      clock_enable_low <= {2{m == 2}};
      settle();
      check_pin({6'h0, serial_clock_in}, inp ? 8'h01 : 8'h03, "clk in");
      check_pin({6'h0, p3_pin_oe[5], p3_pin_oe[2]}, inp ? 8'h00 : 8'h03, "clk oe");
      if (!inp)
        check_pin({6'h0, p3_pin_o[5], p3_pin_o[2]}, 8'h01, "clk o");
      check_pin({6'h0, external_interrupt_in_n}, 8'h03, "irq off");
    end
    {clock_enable_high, clocked_mode, clock_enable_low} <= '0;
    settle();
    check_pin({6'h0, external_interrupt_in_n}, 8'h01, "irq on");
    apb(1'b1, p34_pkg::OFS_DDR, 32'h24);
    settle();
    check_pin({6'h0, external_interrupt_in_n}, 8'h03, "irq output pin");
    $display("test serial pins done");
    apb(1'b1, p34_pkg::OFS_IPINSEL, 32'h3C);
    hw_standby <= 1'b1;
    @(posedge pclk);
    hw_standby <= 1'b0;
    rchk(p34_pkg::OFS_IPINSEL, 32'h0);
    rchk(p34_pkg::OFS_DR, 32'h0);
    apb(1'b1, p34_pkg::OFS_IPINSEL, 32'hC3);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rchk(p34_pkg::OFS_IPINSEL, 32'h0);
    $display("test standby done");
    end_sim();
  end

  // Whole run needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    end_sim();
  end
endmodule : test_port3_port4_pin_function_select
`default_nettype wire
